// ==== serial_config_write_receiver.sv ====
`timescale 1ns/1ps
module serial_config_write_receiver (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // serial pins
    input wire logic serial_clock_pin_in,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe_out,
    // configuration to the device
    output serial_config_pkg::config_bytes_t config_out,
    output logic config_update_out
);

    typedef enum {
        ST_IDLE,
        ST_BITS,
        ST_ACK,
        ST_IGNORE
    } state_t;

    state_t state;
    state_t next_state;
    logic scl_prev;
    logic next_scl_prev;
    logic sda_prev;
    logic next_sda_prev;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [3:0] pos;
    logic [3:0] next_pos;
    logic ack_drive;
    logic next_ack_drive;
    logic ack_seen_low;
    logic next_ack_seen_low;
    serial_config_pkg::config_bytes_t cfg;
    serial_config_pkg::config_bytes_t next_cfg;
    logic update;
    logic next_update;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] full_byte;
    logic [serial_config_pkg::NUM_DATA_BYTES-1:0] byte_load;

    assign scl_rise = serial_clock_pin_in && !scl_prev;
    assign scl_fall = !serial_clock_pin_in && scl_prev;
    assign start_cond = serial_clock_pin_in && scl_prev && sda_prev && !serial_data_pin_in;
    assign stop_cond = serial_clock_pin_in && scl_prev && !sda_prev && serial_data_pin_in;
    // byte as it stands once the eighth bit arrives
    assign full_byte = {shift[6:0], serial_data_pin_in};

    // one load strobe per configuration byte
    for (genvar j = 0; j < serial_config_pkg::NUM_DATA_BYTES; j++)
    begin : g_byte_load
        assign byte_load[j] = (pos == serial_config_pkg::POS_FIRST_DATA + 4'(j));
    end

    // bus line history, idle high so no false condition after reset
    always_comb
    begin
        next_scl_prev = serial_clock_pin_in;
        next_sda_prev = serial_data_pin_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            scl_prev <= next_scl_prev;
            sda_prev <= next_sda_prev;
        end
    end

    always_comb
    begin
        next_state = state;
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_pos = pos;
        next_ack_drive = ack_drive;
        next_ack_seen_low = ack_seen_low;
        next_cfg = cfg;
        next_update = 1'b0;
        if (start_cond)
        begin
            next_state = ST_BITS;
            next_bit_cnt = serial_config_pkg::BIT_MSB;
            next_pos = serial_config_pkg::POS_ADDRESS;
            next_ack_drive = 1'b0;
        end
        else if (stop_cond)
        begin
            next_state = ST_IDLE;
            next_ack_drive = 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    next_ack_drive = 1'b0;
                end
                ST_BITS:
                begin
                    if (scl_rise)
                    begin
                        next_shift = full_byte;
                        if (bit_cnt == 3'h0)
                        begin
                            next_bit_cnt = serial_config_pkg::BIT_MSB;
                            next_ack_seen_low = 1'b0;
                            next_state = ST_ACK;
                            if (pos == serial_config_pkg::POS_ADDRESS
                                && full_byte != serial_config_pkg::OWN_ADDRESS)
                            begin
                                next_state = ST_IGNORE;
                            end
                            else
                            begin
                                for (int j = 0; j < serial_config_pkg::NUM_DATA_BYTES; j++)
                                begin
                                    if (byte_load[j])
                                    begin
                                        next_cfg[j * 8 +: 8] = full_byte;
                                        next_update = 1'b1;
                                    end
                                end
                            end
                            // command and count positions fall through, value unused
                        end
                        else
                        begin
                            next_bit_cnt = bit_cnt - 3'h1;
                        end
                    end
                end
                ST_ACK:
                begin
                    // pull data low from the fall after bit 0 to the fall after the ack
                    if (scl_fall)
                    begin
                        if (!ack_seen_low)
                        begin
                            next_ack_drive = 1'b1;
                            next_ack_seen_low = 1'b1;
                        end
                        else
                        begin
                            next_ack_drive = 1'b0;
                            if (pos == serial_config_pkg::POS_LAST_DATA)
                            begin
                                next_state = ST_IGNORE;
                            end
                            else
                            begin
                                next_pos = pos + 4'h1;
                                next_state = ST_BITS;
                            end
                        end
                    end
                end
                ST_IGNORE:
                begin
                    next_ack_drive = 1'b0;
                end
                default:
                begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= serial_config_pkg::BIT_MSB;
            pos <= serial_config_pkg::POS_ADDRESS;
            ack_drive <= 1'b0;
            ack_seen_low <= 1'b0;
            cfg <= serial_config_pkg::CONFIG_DEFAULT;
            update <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            pos <= next_pos;
            ack_drive <= next_ack_drive;
            ack_seen_low <= next_ack_seen_low;
            cfg <= next_cfg;
            update <= next_update;
        end
    end

    // open drain: only ever pulls low, no read data path
    assign serial_data_pin_out = 1'b0;
    assign serial_data_pin_oe_out = ack_drive;
    assign config_out = cfg;
    assign config_update_out = update;

endmodule : serial_config_write_receiver

// ==== serial_config_pkg.sv ====
package serial_config_pkg;

    // own bus address, seven address bits plus write bit of zero
    localparam logic [7:0] OWN_ADDRESS = 8'hD2;
    localparam int NUM_DATA_BYTES = 8;
    // byte positions counted from zero: address, command, count, data
    localparam logic [3:0] POS_ADDRESS = 4'h0;
    localparam logic [3:0] POS_COMMAND = 4'h1;
    localparam logic [3:0] POS_COUNT = 4'h2;
    localparam logic [3:0] POS_FIRST_DATA = 4'h3;
    localparam logic [3:0] POS_LAST_DATA = 4'hA;
    localparam logic [2:0] BIT_MSB = 3'h7;
    // power-up defaults of the eight data bytes
    localparam logic [7:0] DEFAULT_BYTE0 = 8'h00;
    localparam logic [7:0] DEFAULT_BYTE1 = 8'h00;
    localparam logic [7:0] DEFAULT_BYTE2 = 8'h00;
    localparam logic [7:0] DEFAULT_BYTE3 = 8'h00;
    localparam logic [7:0] DEFAULT_BYTE4 = 8'h60;
    localparam logic [7:0] DEFAULT_BYTE5 = 8'h70;
    localparam logic [7:0] DEFAULT_BYTE6 = 8'h00;
    localparam logic [7:0] DEFAULT_BYTE7 = 8'h00;

    typedef struct packed {
        logic [7:0] byte7;
        logic [7:0] byte6;
        logic [7:0] byte5;
        logic [7:0] byte4;
        logic [7:0] byte3;
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } config_bytes_t;

    localparam config_bytes_t CONFIG_DEFAULT = '{
        DEFAULT_BYTE7, DEFAULT_BYTE6, DEFAULT_BYTE5, DEFAULT_BYTE4,
        DEFAULT_BYTE3, DEFAULT_BYTE2, DEFAULT_BYTE1, DEFAULT_BYTE0
    };

endpackage : serial_config_pkg

// ==== serial_config_checker_asserts.sv ====
`timescale 1ns/1ps
module serial_config_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // watched ports
    input wire logic serial_clock_pin_in,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe_out,
    input wire serial_config_pkg::config_bytes_t config_out,
    input wire logic config_update_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    low_only_a: assert property (!serial_data_pin_out) else $error("pin high");
    cfg_hold_a: assert property (!config_update_out |-> $stable(config_out))
        else $error("config moved");
    upd_pulse_a: assert property (config_update_out |=> !config_update_out)
        else $error("long update");
    upd_clk_a: assert property (config_update_out |-> serial_clock_pin_in)
        else $error("update timing");
    upd_ack_a: assert property (config_update_out |-> ##[1:40] serial_data_pin_oe_out)
        else $error("no ack");
    ack_edge_a: assert property ($changed(serial_data_pin_oe_out) |-> !serial_clock_pin_in)
        else $error("ack edge");
    ack_hold_a: assert property (serial_data_pin_oe_out && serial_clock_pin_in
        |=> serial_data_pin_oe_out) else $error("ack drop");
    ack_end_a: assert property ($rose(serial_data_pin_oe_out) |-> ##[1:40]
        !serial_data_pin_oe_out) else $error("ack stuck");
endmodule : serial_config_checker
bind serial_config_write_receiver serial_config_checker u_chk (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .serial_clock_pin_in(serial_clock_pin_in),
    .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe_out(serial_data_pin_oe_out),
    .config_out(config_out), .config_update_out(config_update_out));

// ==== serial_host_model.sv ====
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input wire logic clk_in,
    // bus lines
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    logic last = 1'b0;
    initial
    begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // wait a quarter bit, then move both lines
    task automatic drv(input logic c, input logic d);
        repeat (4) @(posedge clk_in);
        scl_out <= c;
        sda_low_out <= d;
        last = d;
    endtask : drv
    // start is c=3 d=1, clock dropped first so it also serves as repeated start
    // stop is c=3 d=6
    task automatic lines(input logic [3:0] c, input logic [3:0] d);
        for (int j = 3; j >= 0; j--)
            drv(c[j], d[j]);
    endtask : lines
    // data only moves while the clock is low
    task automatic put_byte(input logic [7:0] v, output logic ack);
        for (int i = 8; i >= 0; i--)
        begin
            drv(1'b0, last);
            drv(1'b0, (i > 0) && !v[i - 1]);
            drv(1'b1, last);
            drv(1'b1, last);
            ack = !sda_in;
        end
    endtask : put_byte
endmodule : serial_host_model

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("Error %0t %h %h", $time, (a), (b)); end end
module testbench;
    logic clk_in;
    logic rst_b_in;
    logic scl;
    logic low;
    logic oe;
    logic dout;
    logic upd;
    logic ack;
    logic own;
    logic [7:0] b;
    serial_config_pkg::config_bytes_t cfg;
    serial_config_pkg::config_bytes_t exp_cfg;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h344bc24f;
    int upd_seen = 0;
    wire sda = !(low || (oe && !dout));
    serial_config_write_receiver u_serial_config_write_receiver (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .serial_clock_pin_in(scl), .serial_data_pin_in(sda),
        .serial_data_pin_out(dout), .serial_data_pin_oe_out(oe), .config_out(cfg),
        .config_update_out(upd));
    serial_host_model u_serial_host_model (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_low_out(low));
    // bits the host may set at byte position p; reserved data bits stay zero
    function automatic logic [7:0] legal_bits(input int p, input logic mine);
        if (!mine || p < 3)
            return 8'hFF;
        else if (p == 7)
            return 8'hFF;
        else if (p == 8)
            return 8'hF0;
        else
            return 8'h00;
    endfunction : legal_bits
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic do_reset();
        rst_b_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        exp_cfg = serial_config_pkg::CONFIG_DEFAULT;
        `CHK(cfg, exp_cfg)
    endtask : do_reset
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (upd === 1'b1)
            upd_seen++;
        if (cycles == 30000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    // t=2 and t=5 random address, t=2 no stop; t=4 cut short; t=7 read address
    initial
    begin
        rst_b_in = 1'b0;
        do_reset();
        for (int t = 0; t < 8; t++)
        begin
            b = serial_config_pkg::OWN_ADDRESS ^ {7'h00, t == 7};
            if (t % 3 == 2)
                b = 8'($random(seed));
            own = (b === serial_config_pkg::OWN_ADDRESS);
            upd_seen = 0;
            u_serial_host_model.lines(4'h3, 4'h1);
            for (int k = 0; k < ((t == 4) ? 6 : 11); k++)
            begin
                u_serial_host_model.put_byte(b, ack);
                `CHK(ack, own)
                if (own && k > 2)
                    exp_cfg[8 * (k - 3) +: 8] = b;
                b = 8'($random(seed)) & legal_bits(k + 1, own);
            end
            if (t != 2)
                u_serial_host_model.lines(4'h3, 4'h6);
            `CHK(cfg, exp_cfg)
            `CHK(upd_seen, own ? ((t == 4) ? 3 : 8) : 0)
        end
        do_reset();
        report_and_stop();
    end
endmodule : testbench
